// >>> logic/adcsl_regs.sv
module adcsl_regs #(
	parameter logic       HD_VALUE    = 1'b0,
	parameter logic [4:0] CF_COUNT    = 5'h01,
	parameter logic [7:0] LMFC_PERIOD = 8'h20
) (
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	input  wire logic                  csb_n,
	input  wire logic                  sclk,
	input  wire logic                  sdio_in,
	output logic                       sdio_out,
	output logic                       sdio_oe_n,
	input  wire logic                  power_down_pin,
	input  wire logic                  sysref,
	output adcsl_pkg::adcsl_power_t    power_ctrl,
	output logic                       driver_power_down,
	output logic                       preemphasis_on,
	output logic [7:0]                 lmfc_phase
);
	import adcsl_pkg::*;

	// pin synchronisers; stage one feeds only stage two
	logic [4:0] sync1, sync2, next_sync1, next_sync2;
	logic       sclk_prev, next_sclk_prev;
	logic       csb_s, sclk_s, sdio_s, pd_s, sysref_s, sclk_rise, sclk_fall;

	adcsl_state_t state, next_state;
	logic [4:0]   bit_cnt, next_bit_cnt;
	logic [15:0]  instr, next_instr;
	logic [7:0]   wshift, next_wshift, rshift, next_rshift;
	logic         sdo, next_sdo, oe_n, next_oe_n;

	// staged and active copies
	logic [7:0] pdm, resv1, resv2, chk, drv, lmfc_ofs, preemph;
	logic [7:0] next_pdm, next_resv1, next_resv2, next_chk, next_drv;
	logic [7:0] next_lmfc_ofs, next_preemph;
	logic [7:0] a_pdm, a_drv, a_lmfc, a_preemph;
	logic [7:0] next_a_pdm, next_a_drv, next_a_lmfc, next_a_preemph;
	logic       chk_set, next_chk_set, xfer, next_xfer;

	logic [7:0]   phase, next_phase;
	adcsl_power_t pwr, next_pwr;
	logic         drv_pd, next_drv_pd, pre_on, next_pre_on;

	logic [7:0] hdcf, chk_calc, rd_val;
	logic       wr_stb;
	logic [1:0] adc_mode, link_mode;

	assign csb_s     = sync2[0];
	assign sclk_s    = sync2[1];
	assign sdio_s    = sync2[2];
	assign pd_s      = sync2[3];
	assign sysref_s  = sync2[4];
	assign sclk_rise = sclk_s & ~sclk_prev;
	assign sclk_fall = ~sclk_s & sclk_prev;

	assign hdcf     = {HD_VALUE, 2'h0, CF_COUNT - 5'h01};
	assign chk_calc = 8'(RST_SPC + hdcf + resv1 + resv2);

	always_comb begin
		case (instr[ADDR_W-1:0])
			ADR_PDM:     rd_val = pdm;
			ADR_SPC:     rd_val = RST_SPC;
			ADR_HDCF:    rd_val = hdcf;
			ADR_RESV1:   rd_val = resv1;
			ADR_RESV2:   rd_val = resv2;
			ADR_CHKSUM:  rd_val = chk_set ? chk : chk_calc;
			ADR_DRV:     rd_val = drv;
			ADR_LMFC:    rd_val = lmfc_ofs;
			ADR_PREEMPH: rd_val = preemph;
			ADR_UPDATE:  rd_val = {7'h00, xfer};
			default:     rd_val = RST_ZERO;
		endcase
	end

	// serial port
	always_comb begin
		next_sync1     = {sysref, power_down_pin, sdio_in, sclk, csb_n};
		next_sync2     = sync1;
		next_sclk_prev = sclk_s;
		next_state     = state;
		next_bit_cnt   = bit_cnt;
		next_instr     = instr;
		next_wshift    = wshift;
		next_rshift    = rshift;
		next_sdo       = sdo;
		next_oe_n      = oe_n;
		wr_stb         = 1'b0;
		if (csb_s) begin
			next_state   = ADCSL_IDLE;
			next_bit_cnt = 5'h00;
			next_oe_n    = 1'b1;
		end else begin
			case (state)
				ADCSL_IDLE: begin
					next_state = ADCSL_INSTR;
				end
				ADCSL_INSTR: begin
					if (sclk_rise) begin
						next_instr   = {instr[14:0], sdio_s};
						next_bit_cnt = bit_cnt + 5'h01;
						if (bit_cnt == INSTR_LAST)
							next_state = instr[BIT_RW-1] ? ADCSL_RDATA : ADCSL_WDATA;
					end
				end
				ADCSL_WDATA: begin
					if (sclk_rise && bit_cnt != DATA_LAST + 5'h01) begin
						next_wshift  = {wshift[6:0], sdio_s};
						next_bit_cnt = bit_cnt + 5'h01;
						wr_stb       = (bit_cnt == DATA_LAST);
					end
				end
				ADCSL_RDATA: begin
					// read value latched lazily on the first falling edge
					if (sclk_fall) begin
						next_oe_n   = 1'b0;
						next_sdo    = (bit_cnt == INSTR_LAST + 5'h01) ? rd_val[7] : rshift[7];
						next_rshift = (bit_cnt == INSTR_LAST + 5'h01) ? {rd_val[6:0], 1'b0}
							: {rshift[6:0], 1'b0};
						next_bit_cnt = bit_cnt + 5'h01;
					end
				end
				default: next_state = ADCSL_IDLE;
			endcase
		end
		if (reset) begin
			next_state   = ADCSL_IDLE;
			next_bit_cnt = 5'h00;
			next_instr   = 16'h0000;
			next_wshift  = RST_ZERO;
			next_rshift  = RST_ZERO;
			next_sdo     = 1'b0;
			next_oe_n    = 1'b1;
		end
	end

	// staged registers and transfer
	always_comb begin
		next_pdm       = pdm;
		next_resv1     = resv1;
		next_resv2     = resv2;
		next_chk       = chk;
		next_chk_set   = chk_set;
		next_drv       = drv;
		next_lmfc_ofs  = lmfc_ofs;
		next_preemph   = preemph;
		next_a_pdm     = a_pdm;
		next_a_drv     = a_drv;
		next_a_lmfc    = a_lmfc;
		next_a_preemph = a_preemph;
		next_xfer      = xfer;
		if (xfer) begin
			next_a_pdm     = pdm;
			next_a_drv     = drv;
			next_a_lmfc    = lmfc_ofs;
			next_a_preemph = preemph;
			next_xfer      = 1'b0;
		end
		// strobe comes with the last data bit, so take the shifted value
		if (wr_stb) begin
			case (instr[ADDR_W-1:0])
				ADR_PDM:     next_pdm      = next_wshift;
				ADR_RESV1:   next_resv1    = next_wshift;
				ADR_RESV2:   next_resv2    = next_wshift;
				ADR_DRV:     next_drv      = next_wshift;
				ADR_LMFC:    next_lmfc_ofs = next_wshift;
				ADR_PREEMPH: next_preemph  = next_wshift;
				ADR_CHKSUM: begin
					next_chk     = next_wshift;
					next_chk_set = 1'b1;
				end
				// a new request wins over the self-clear
				ADR_UPDATE:  next_xfer = next_wshift[BIT_XFER] | next_xfer;
				default: ;
			endcase
		end
		if (reset) begin
			next_pdm       = RST_ZERO;
			next_resv1     = RST_ZERO;
			next_resv2     = RST_ZERO;
			next_chk       = RST_ZERO;
			next_chk_set   = 1'b0;
			next_drv       = RST_DRV;
			next_lmfc_ofs  = RST_ZERO;
			next_preemph   = RST_PREEMPH;
			next_a_pdm     = RST_ZERO;
			next_a_drv     = RST_DRV;
			next_a_lmfc    = RST_ZERO;
			next_a_preemph = RST_PREEMPH;
			next_xfer      = 1'b0;
		end
	end

	// power control
	always_comb begin
		adc_mode  = a_pdm[ADC_MODE_LSB +: 2];
		link_mode = a_pdm[LINK_MODE_LSB +: 2];
		if (pd_s) begin
			if (!a_pdm[BIT_PIN_MODE]) begin
				adc_mode  = ADCSL_PWR_DOWN;
				link_mode = ADCSL_PWR_DOWN;
			end else begin
				adc_mode  = ADCSL_PWR_STBY;
				link_mode = a_pdm[BIT_LINK_STBY] ? ADCSL_PWR_STBY
					: ADCSL_PWR_NORMAL;
			end
		end
		next_pwr.adc_power_down = (adc_mode == ADCSL_PWR_DOWN);
		next_pwr.adc_standby    = (adc_mode == ADCSL_PWR_STBY);
		next_pwr.link_pll_on    = (link_mode != ADCSL_PWR_DOWN);
		next_pwr.serializer_on  = (link_mode == ADCSL_PWR_NORMAL);
		next_pwr.link_clock_run = (link_mode == ADCSL_PWR_NORMAL);
		next_pwr.link_reset     = (link_mode != ADCSL_PWR_NORMAL);
		next_drv_pd = a_drv[BIT_DRV_PD];
		next_pre_on = (a_preemph == PREEMPH_ON);
		// phase counter runs on the system clock as a stand-in for the frame clock
		if (sysref_s)
			next_phase = a_lmfc;
		else if (phase >= LMFC_PERIOD - 8'h01)
			next_phase = 8'h00;
		else
			next_phase = phase + 8'h01;
		if (reset) begin
			next_pwr    = '0;
			next_drv_pd = 1'b0;
			next_pre_on = 1'b0;
			next_phase  = 8'h00;
		end
	end

	always_ff @(posedge sys_clk) begin
		sync1     <= next_sync1;
		sync2     <= next_sync2;
		sclk_prev <= next_sclk_prev;
		state     <= next_state;
		bit_cnt   <= next_bit_cnt;
		instr     <= next_instr;
		wshift    <= next_wshift;
		rshift    <= next_rshift;
		sdo       <= next_sdo;
		oe_n      <= next_oe_n;
		pdm       <= next_pdm;
		resv1     <= next_resv1;
		resv2     <= next_resv2;
		chk       <= next_chk;
		chk_set   <= next_chk_set;
		drv       <= next_drv;
		lmfc_ofs  <= next_lmfc_ofs;
		preemph   <= next_preemph;
		a_pdm     <= next_a_pdm;
		a_drv     <= next_a_drv;
		a_lmfc    <= next_a_lmfc;
		a_preemph <= next_a_preemph;
		xfer      <= next_xfer;
		pwr       <= next_pwr;
		drv_pd    <= next_drv_pd;
		pre_on    <= next_pre_on;
		phase     <= next_phase;
	end

	assign sdio_out          = sdo;
	assign sdio_oe_n         = oe_n;
	assign power_ctrl        = pwr;
	assign driver_power_down = drv_pd;
	assign preemphasis_on    = pre_on;
	assign lmfc_phase        = phase;
endmodule : adcsl_regs

// >>> logic/adcsl_pkg.sv
package adcsl_pkg;
	localparam int          ADDR_W       = 13;
	localparam logic [12:0] ADR_PDM      = 13'h0008;
	localparam logic [12:0] ADR_SPC      = 13'h0074;
	localparam logic [12:0] ADR_HDCF     = 13'h0075;
	localparam logic [12:0] ADR_RESV1    = 13'h0076;
	localparam logic [12:0] ADR_RESV2    = 13'h0077;
	localparam logic [12:0] ADR_CHKSUM   = 13'h0079;
	localparam logic [12:0] ADR_DRV      = 13'h0080;
	localparam logic [12:0] ADR_LMFC     = 13'h008b;
	localparam logic [12:0] ADR_PREEMPH  = 13'h00a8;
	localparam logic [12:0] ADR_UPDATE   = 13'h00ff;

	localparam logic [7:0]  RST_ZERO     = 8'h00;
	localparam logic [7:0]  RST_SPC      = 8'h20;
	localparam logic [7:0]  RST_DRV      = 8'h00;
	localparam logic [7:0]  RST_PREEMPH  = 8'h04;
	localparam logic [7:0]  PREEMPH_ON   = 8'h14;

	// register bit fields: power-down mode, transfer, driver power-down, HD
	localparam int BIT_PIN_MODE   = 5;
	localparam int BIT_LINK_STBY  = 4;
	localparam int LINK_MODE_LSB  = 2;
	localparam int ADC_MODE_LSB   = 0;
	localparam int BIT_XFER       = 0;
	localparam int BIT_DRV_PD     = 0;
	localparam int BIT_HD         = 7;

	// instruction: read flag, two length bits, 13-bit address
	localparam logic [4:0] INSTR_LAST = 5'h0f;
	localparam logic [4:0] DATA_LAST  = 5'h17;
	localparam int         BIT_RW     = 15;

	typedef enum logic [1:0] {
		ADCSL_PWR_NORMAL = 2'h0,
		ADCSL_PWR_DOWN   = 2'h1,
		ADCSL_PWR_STBY   = 2'h2
	} adcsl_pwr_t;

	typedef enum logic [1:0] {
		ADCSL_IDLE  = 2'h0,
		ADCSL_INSTR = 2'h1,
		ADCSL_WDATA = 2'h3,
		ADCSL_RDATA = 2'h2
	} adcsl_state_t;

	typedef struct packed {
		logic adc_power_down;
		logic adc_standby;
		logic link_pll_on;
		logic serializer_on;
		logic link_clock_run;
		logic link_reset;
	} adcsl_power_t;
endpackage : adcsl_pkg

// >>> sim/adcsl_regs_chk.sv
module adcsl_regs_chk #(
	parameter logic [7:0] LMFC_PERIOD = 8'h20
) (
	input wire logic                 sys_clk,
	input wire logic                 reset,
	input wire logic                 sysref,
	input wire logic                 power_down_pin,
	input wire adcsl_pkg::adcsl_power_t power_ctrl,
	input wire logic [7:0]           lmfc_phase
);
	timeunit 1ns;
	timeprecision 1ps;
	import adcsl_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// four samples cover the two synchronizer flops plus margin
	sequence sysref_held;
		sysref [*4];
	endsequence
	sequence sysref_quiet;
		!sysref [*4];
	endsequence
	lmfc_load_a: assert property (sysref_held |=> $stable(lmfc_phase))
		else $error("phase counter moved while sysref held");
	lmfc_count_a: assert property (sysref_quiet ##0 !$past(reset)
		|=> lmfc_phase == (($past(lmfc_phase) + 8'h01) % LMFC_PERIOD))
		else $error("phase counter step wrong");
	pd_exclusive_a: assert property (!(power_ctrl.adc_power_down && power_ctrl.adc_standby))
		else $error("power-down and standby together");
	// pin reaches power_ctrl through two sync flops and one register
	full_pd_link_a: assert property ($past(power_down_pin, 3) && power_ctrl.adc_power_down
		|-> !power_ctrl.link_pll_on && power_ctrl.link_reset) else $error("link alive in power-down");
	stby_link_a: assert property ($past(power_down_pin, 3) && power_ctrl.adc_standby
		|-> power_ctrl.link_pll_on) else $error("link pll off in standby");
	pll_off_a: assert property (!$past(reset) && !power_ctrl.link_pll_on
		|-> power_ctrl.link_reset && !power_ctrl.serializer_on) else $error("pll off, link live");
	link_hold_a: assert property (power_ctrl.link_reset
		|-> !power_ctrl.serializer_on && !power_ctrl.link_clock_run) else $error("link held but runs");
	link_run_a: assert property (power_ctrl.link_clock_run
		|-> power_ctrl.serializer_on && power_ctrl.link_pll_on && !power_ctrl.link_reset)
		else $error("link clocks run outside normal mode");
endmodule : adcsl_regs_chk

bind adcsl_regs adcsl_regs_chk #(.LMFC_PERIOD(LMFC_PERIOD)) i_adcsl_regs_chk (
	.sys_clk(sys_clk), .reset(reset), .sysref(sysref), .power_down_pin(power_down_pin),
	.power_ctrl(power_ctrl),
	.lmfc_phase(lmfc_phase));

// >>> sim/adcsl_host.sv
module adcsl_host (
	input  wire logic sys_clk,
	input  wire logic sdio_out,
	input  wire logic sdio_oe_n,
	output logic      csb_n,
	output logic      sclk,
	output logic      sdio_in
);
	timeunit 1ns;
	timeprecision 1ps;
	import adcsl_pkg::*;
	logic oe_ok;
	initial begin
		csb_n = 1'b1;
		sclk = 1'b0;
		sdio_in = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick
	// half period of 5 clocks: the port samples sclk through two flops
	task automatic frame(input logic [15:0] ins, input logic [7:0] wd, output logic [7:0] rd);
		logic [23:0] bits;
		bits = {ins, wd};
		rd = 8'h00;
		oe_ok = 1'b1;
		csb_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sclk = 1'b0;
			// released line during read data toggles, never a stale level
			sdio_in = (ins[15] && i < 8) ? ~sdio_in : bits[i];
			tick(5);
			rd = {rd[6:0], sdio_out};
			// enable must be low exactly while read data is driven
			if (sdio_oe_n !== !(ins[15] && i < 8))
				oe_ok = 1'b0;
			sclk = 1'b1;
			tick(5);
		end
		sclk = 1'b0;
		tick(2);
		csb_n = 1'b1;
		tick(6);
	endtask : frame
	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		logic [7:0] r;
		frame({3'b000, a}, d, r);
	endtask : wr
	task automatic rd(input logic [12:0] a, output logic [7:0] d);
		frame({3'b100, a}, 8'h00, d);
	endtask : rd
	task automatic apply();
		wr(ADR_UPDATE, 8'h01);
	endtask : apply
endmodule : adcsl_host

// >>> sim/adcsl_regs_test.sv
module adcsl_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	import adcsl_pkg::*;
	localparam logic       HD   = 1'b1;
	localparam logic [4:0] CF   = 5'h03;
	localparam logic [7:0] HDCF = {HD, 2'b00, CF - 5'h01};
	logic         sys_clk, reset, csb_n, sclk, sdio_in, sdio_out, sdio_oe_n;
	logic         power_down_pin, sysref, driver_power_down, preemphasis_on;
	logic [7:0]   lmfc_phase, r;
	adcsl_power_t power_ctrl;
	int           bad_count, check_count;
	adcsl_regs #(.HD_VALUE(HD), .CF_COUNT(CF)) i_adcsl_regs (
		.sys_clk(sys_clk), .reset(reset), .csb_n(csb_n), .sclk(sclk), .sdio_in(sdio_in),
		.sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .power_down_pin(power_down_pin),
		.sysref(sysref), .power_ctrl(power_ctrl), .driver_power_down(driver_power_down),
		.preemphasis_on(preemphasis_on), .lmfc_phase(lmfc_phase));
	adcsl_host i_adcsl_host (
		.sys_clk(sys_clk), .sdio_out(sdio_out), .sdio_oe_n(sdio_oe_n), .csb_n(csb_n),
		.sclk(sclk), .sdio_in(sdio_in));
	initial sys_clk = 1'b0;
	always #20 sys_clk = ~sys_clk;
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic rdchk(input logic [12:0] a, input logic [7:0] exp);
		i_adcsl_host.rd(a, r);
		cmp(r, exp);
		cmp({7'h00, i_adcsl_host.oe_ok}, 8'h01);
	endtask : rdchk
	task automatic chk_fixed();
		rdchk(ADR_SPC, RST_SPC);
		rdchk(ADR_HDCF, HDCF);
		rdchk(ADR_PREEMPH, RST_PREEMPH);
		rdchk(ADR_DRV, RST_DRV);
		rdchk(13'h0010, RST_ZERO);
		cmp({2'b00, power_ctrl}, 8'h0e);
		i_adcsl_host.wr(ADR_HDCF, 8'h55);
		rdchk(ADR_HDCF, HDCF);
	endtask : chk_fixed
	task automatic chk_stage();
		i_adcsl_host.wr(ADR_PREEMPH, PREEMPH_ON);
		i_adcsl_host.wr(ADR_DRV, 8'h01);
		cmp({6'h00, preemphasis_on, driver_power_down}, 8'h00);
		rdchk(ADR_PREEMPH, PREEMPH_ON);
		i_adcsl_host.apply();
		cmp({6'h00, preemphasis_on, driver_power_down}, 8'h03);
		rdchk(ADR_UPDATE, 8'h00);
		i_adcsl_host.wr(ADR_PREEMPH, RST_PREEMPH);
		i_adcsl_host.apply();
		cmp({6'h00, preemphasis_on, driver_power_down}, 8'h01);
	endtask : chk_stage
	task automatic chk_chksum();
		i_adcsl_host.wr(ADR_RESV1, 8'h11);
		i_adcsl_host.wr(ADR_RESV2, 8'h02);
		rdchk(ADR_CHKSUM, RST_SPC + HDCF + 8'h11 + 8'h02);
		i_adcsl_host.wr(ADR_CHKSUM, 8'h5a);
		rdchk(ADR_CHKSUM, 8'h5a);
	endtask : chk_chksum
	task automatic chk_lmfc();
		i_adcsl_host.wr(ADR_LMFC, 8'h05);
		i_adcsl_host.apply();
		sysref = 1'b1;
		i_adcsl_host.tick(6);
		cmp(lmfc_phase, 8'h05);
		sysref = 1'b0;
		i_adcsl_host.tick(40);
	endtask : chk_lmfc
	task automatic chk_power();
		logic [7:0] mode [6] = '{8'h00, 8'h20, 8'h30, 8'h30, 8'h04, 8'h08};
		logic       pin  [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
		logic [7:0] exp  [6] = '{8'h21, 8'h1e, 8'h19, 8'h0e, 8'h01, 8'h09};
		for (int i = 0; i < 6; i++) begin
			i_adcsl_host.wr(ADR_PDM, mode[i]);
			i_adcsl_host.apply();
			power_down_pin = pin[i];
			i_adcsl_host.tick(5);
			cmp({2'b00, power_ctrl}, exp[i]);
			power_down_pin = 1'b0;
		end
	endtask : chk_power
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run
	initial begin
		reset = 1'b1;
		sysref = 1'b0;
		power_down_pin = 1'b0;
		bad_count = 0;
		check_count = 0;
		repeat (10) @(posedge sys_clk);
		#1 reset = 1'b0;
		i_adcsl_host.tick(4);
		chk_fixed();
		chk_stage();
		chk_chksum();
		chk_lmfc();
		chk_power();
		complete_run();
	end
	// about five times the expected run length
	initial begin
		repeat (40000) @(posedge sys_clk);
		bad_count++;
		complete_run();
	end
endmodule : adcsl_regs_test
